// *** hdl/placeholder_unused.sv ***
/*
  unused
*/

// *** hdl/qpc_command_unit.sv ***
/*
  Quad potentiometer command unit: serial slave byte engine, wiper and stored
  setting registers, write protection and the non-volatile programming cycle.
  Assumes a framing front-end that marks START (in the serial clock domain)
  and STOP (a level, asynchronous) and an open-drain data wire resolved outside.
*/
`timescale 1ns/100ps
`default_nettype none

module qpc_command_unit
  import qpc_pkg::*;
#(
  parameter logic [3:0]  DEV_TYPE_ID   = DEV_TYPE_DEFAULT,
  parameter int unsigned PROG_CYC_PARM = PROG_CYCLES
) (
  // system clock and reset
  input  wire logic                         I_CLOCK,
  input  wire logic                         I_NRST,
  // serial link from the bus master
  input  wire logic                         I_SCL,
  input  wire logic                         I_SDA,
  input  wire logic                         I_FRAME_START,
  input  wire logic                         I_FRAME_STOP,
  output logic                              O_SDA,
  output logic                              O_SDA_OE_N,
  // strap and protect pins
  input  wire logic                         I_WP_N,
  input  wire logic [3:0]                   I_HW_ADDR,
  // potentiometer side
  output logic [NUM_POTS*NUM_TAPS-1:0]      O_TAP_SEL,
  output logic [NUM_POTS*8-1:0]             O_WIPER,
  output logic                              O_BUSY
);

  // link domain state
  qpc_link_e        lst_q, lst_d;
  logic [3:0]       bit_q, bit_d;
  logic [7:0]       sh_q, sh_d;
  logic             ack_q, ack_d;
  logic [7:0]       instr_q, instr_d;
  logic [7:0]       tx_q, tx_d;
  logic [7:0]       wiper_q [NUM_POTS];
  logic [7:0]       wiper_d [NUM_POTS];
  logic             pend_q, pend_d;
  qpc_pend_e        pkind_q, pkind_d;
  logic [1:0]       ppot_q, ppot_d;
  logic [1:0]       psel_q, psel_d;
  logic [7:0]       pdata_q, pdata_d;
  logic             stgl_q, stgl_d;
  logic             step_vld_q, step_vld_d, step_up_q, step_up_d;
  logic [3:0]       hwa_s1_q, hwa_s2_q;
  logic             wpl_s1_q, wpl_s2_q;
  logic             bsy_s1_q, bsy_s2_q;
  logic             drv_q, drv_d;
  logic [NUM_TAPS-1:0] tap_q [NUM_POTS];
  logic [NUM_TAPS-1:0] tap_d [NUM_POTS];

  // system domain state
  logic             stp_s1_q, stp_s2_q, stp_s3_q;
  logic             wps_s1_q, wps_s2_q;
  logic             stg_s1_q, stg_s2_q, stg_s3_q;
  logic             wp_seen_q, wp_seen_d;
  logic             busy_q, busy_d;
  logic [PROG_CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]       stored_q [NUM_STORED];
  logic [7:0]       stored_d [NUM_STORED];

  logic [7:0]       byte_in;
  qpc_link_e        cur_st;
  logic [3:0]       cur_bit;
  logic [1:0]       ipot;
  logic [1:0]       isel;

  function automatic logic instr_legal(input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    case (b[OPC_MSB:OPC_LSB])
      OP_RD_WIPER, OP_WR_WIPER, OP_STEP: ok = (b[SEL_MSB:SEL_LSB] == 2'b00);
      OP_RD_STORED, OP_WR_STORED, OP_COPY_S2W, OP_COPY_W2S: ok = 1'b1;
      OP_GANG_S2W, OP_GANG_W2S: ok = (b[POT_MSB:POT_LSB] == 2'b00);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // value returned by a read instruction
  function automatic logic [7:0] read_value(input logic [7:0] ins,
                                            input logic [7:0] w [NUM_POTS],
                                            input logic [7:0] s [NUM_STORED]);
    logic [7:0] v;
    v = s[{ins[POT_MSB:POT_LSB], ins[SEL_MSB:SEL_LSB]}];
    if (ins[OPC_MSB:OPC_LSB] == OP_RD_WIPER) begin
      v = w[ins[POT_MSB:POT_LSB]];
    end
    return v;
  endfunction

  assign ipot = instr_q[POT_MSB:POT_LSB];
  assign isel = instr_q[SEL_MSB:SEL_LSB];

  // stored settings are read across domains only while they stand still:
  // they change during programming, when the link refuses every frame
  always_comb begin
    lst_d   = lst_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    ack_d   = ack_q;
    instr_d = instr_q;
    tx_d    = tx_q;
    wiper_d = wiper_q;
    pend_d  = pend_q;
    pkind_d = pkind_q;
    ppot_d  = ppot_q;
    psel_d  = psel_q;
    pdata_d = pdata_q;
    stgl_d  = stgl_q;
    step_vld_d = step_vld_q;
    step_up_d  = step_up_q;
    cur_st  = lst_q;
    cur_bit = bit_q;
    byte_in = {sh_q[6:0], I_SDA};
    if (I_FRAME_START) begin
      cur_st  = L_ADDR;
      cur_bit = 4'h0;
      ack_d   = 1'b0;
      pend_d  = 1'b0;
      stgl_d  = ~stgl_q;
      step_vld_d = 1'b0;
    end
    lst_d = cur_st;
    case (cur_st)
      L_ADDR, L_INSTR, L_DATA, L_READ: begin
        if (cur_bit == ACK_BIT) begin
          bit_d = 4'h0;
          ack_d = 1'b0;
          case (cur_st)
            L_ADDR: begin
              lst_d = ack_q ? L_INSTR : L_WAIT;
            end
            L_INSTR: begin
              lst_d   = L_WAIT;
              instr_d = sh_q;
              if (ack_q) begin
                case (sh_q[OPC_MSB:OPC_LSB])
                  OP_RD_WIPER, OP_RD_STORED: begin
                    tx_d  = read_value(sh_q, wiper_q, stored_q);
                    lst_d = L_READ;
                  end
                  OP_WR_WIPER, OP_WR_STORED: begin
                    lst_d = L_DATA;
                  end
                  OP_COPY_S2W: begin
                    wiper_d[sh_q[POT_MSB:POT_LSB]] =
                      stored_q[{sh_q[POT_MSB:POT_LSB], sh_q[SEL_MSB:SEL_LSB]}];
                  end
                  OP_GANG_S2W: begin
                    for (int p = 0; p < NUM_POTS; p++) begin
                      wiper_d[p] = stored_q[{2'(p), sh_q[SEL_MSB:SEL_LSB]}];
                    end
                  end
                  OP_COPY_W2S, OP_GANG_W2S: begin
                    pend_d  = 1'b1;
                    pkind_d = (sh_q[OPC_MSB:OPC_LSB] == OP_GANG_W2S) ? PEND_GANG : PEND_COPY;
                    ppot_d  = sh_q[POT_MSB:POT_LSB];
                    psel_d  = sh_q[SEL_MSB:SEL_LSB];
                  end
                  OP_STEP: begin
                    lst_d = L_STEP;
                  end
                  default: lst_d = L_WAIT;
                endcase
              end
            end
            L_DATA: begin
              lst_d = L_WAIT;
              if (ack_q) begin
                if (instr_q[OPC_MSB:OPC_LSB] == OP_WR_WIPER) begin
                  wiper_d[ipot] = sh_q;
                end else begin
                  pend_d  = 1'b1;
                  pkind_d = PEND_WRITE;
                  ppot_d  = ipot;
                  psel_d  = isel;
                  pdata_d = sh_q;
                end
              end
            end
            default: begin
              // master acknowledge decides whether the byte is sent again
              if (!I_SDA) begin
                tx_d = read_value(instr_q, wiper_q, stored_q);
              end else begin
                lst_d = L_WAIT;
              end
            end
          endcase
        end else begin
          sh_d  = byte_in;
          bit_d = cur_bit + 4'h1;
          if (cur_bit == LAST_DATA_BIT) begin
            case (cur_st)
              L_ADDR: ack_d = (byte_in[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEV_TYPE_ID) &&
                              (byte_in[ADDR_HW_MSB:ADDR_HW_LSB] == hwa_s2_q) &&
                              !bsy_s2_q;
              L_INSTR: ack_d = instr_legal(byte_in);
              L_DATA: ack_d = (instr_q[OPC_MSB:OPC_LSB] == OP_WR_WIPER) || wpl_s2_q;
              default: ack_d = 1'b0;
            endcase
          end
        end
      end
      L_STEP: begin
        // a step lands one edge late, so the STOP clock only completes the last pulse
        step_vld_d = 1'b1;
        step_up_d  = I_SDA;
        if (step_vld_q && step_up_q) begin
          if (wiper_q[ipot] != WIPER_MAX) begin
            wiper_d[ipot] = wiper_q[ipot] + 8'h01;
          end
        end else if (step_vld_q && (wiper_q[ipot] != WIPER_MIN)) begin
          wiper_d[ipot] = wiper_q[ipot] - 8'h01;
        end
      end
      default: ;
    endcase
  end

  for (genvar p = 0; p < NUM_POTS; p++) begin : g_pot
    always_comb tap_d[p] = NUM_TAPS'(1) << wiper_d[p];
    assign O_WIPER[p*8 +: 8]                 = wiper_q[p];
    assign O_TAP_SEL[p*NUM_TAPS +: NUM_TAPS] = tap_q[p];
  end

  // wire changes on the falling edge, so it stands through the sampled high phase
  always_comb begin
    drv_d = 1'b0;
    if ((lst_q == L_READ) && (bit_q != ACK_BIT)) begin
      drv_d = !tx_q[3'(LAST_DATA_BIT - bit_q)];
    end else if (ack_q && (bit_q == ACK_BIT) && (lst_q inside {L_ADDR, L_INSTR, L_DATA})) begin
      drv_d = 1'b1;
    end
    if (bsy_s2_q) begin
      drv_d = 1'b0;
    end
  end

  always_ff @(negedge I_SCL or negedge I_NRST) begin
    if (!I_NRST) begin
      drv_q <= 1'b0;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign O_SDA      = 1'b0;
  assign O_SDA_OE_N = ~drv_q;
  assign O_BUSY     = busy_q;

  always_ff @(posedge I_SCL or negedge I_NRST) begin
    if (!I_NRST) begin
      lst_q      <= L_IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      ack_q      <= 1'b0;
      instr_q    <= 8'h00;
      tx_q       <= 8'h00;
      // first stored settings reset to the same value, so this is the power-up load
      wiper_q    <= '{default: STORED_RESET};
      tap_q      <= '{default: NUM_TAPS'(1) << STORED_RESET};
      pend_q     <= 1'b0;
      pkind_q    <= PEND_WRITE;
      ppot_q     <= 2'h0;
      psel_q     <= 2'h0;
      pdata_q    <= 8'h00;
      stgl_q     <= 1'b0;
      step_vld_q <= 1'b0;
      step_up_q  <= 1'b0;
      hwa_s1_q   <= 4'h0;
      hwa_s2_q   <= 4'h0;
      wpl_s1_q   <= 1'b1;
      wpl_s2_q   <= 1'b1;
      bsy_s1_q   <= 1'b0;
      bsy_s2_q   <= 1'b0;
    end else begin
      lst_q      <= lst_d;
      bit_q      <= bit_d;
      sh_q       <= sh_d;
      ack_q      <= ack_d;
      instr_q    <= instr_d;
      tx_q       <= tx_d;
      wiper_q    <= wiper_d;
      tap_q      <= tap_d;
      pend_q     <= pend_d;
      pkind_q    <= pkind_d;
      ppot_q     <= ppot_d;
      psel_q     <= psel_d;
      pdata_q    <= pdata_d;
      stgl_q     <= stgl_d;
      step_vld_q <= step_vld_d;
      step_up_q  <= step_up_d;
      hwa_s1_q   <= I_HW_ADDR;
      hwa_s2_q   <= hwa_s1_q;
      wpl_s1_q   <= I_WP_N;
      wpl_s2_q   <= wpl_s1_q;
      bsy_s1_q   <= busy_q;
      bsy_s2_q   <= bsy_s1_q;
    end
  end

  // link registers read here stand still from STOP to the next START
  always_comb begin
    busy_d    = busy_q;
    cnt_d     = cnt_q;
    stored_d  = stored_q;
    // a protect drop in the cycle the new START is seen wins over the clear
    wp_seen_d = (wp_seen_q && (stg_s2_q == stg_s3_q)) || (!wps_s2_q && !busy_q);
    if (busy_q) begin
      if (cnt_q == PROG_CNT_W'(PROG_CYC_PARM - 1)) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q + PROG_CNT_W'(1);
      end
    end else if (stp_s2_q && !stp_s3_q && pend_q && wps_s2_q && !wp_seen_q) begin
      busy_d = 1'b1;
      cnt_d  = '0;
      case (pkind_q)
        PEND_WRITE: stored_d[{ppot_q, psel_q}] = pdata_q;
        PEND_COPY:  stored_d[{ppot_q, psel_q}] = wiper_q[ppot_q];
        default: begin
          for (int p = 0; p < NUM_POTS; p++) begin
            stored_d[{2'(p), psel_q}] = wiper_q[p];
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      stp_s1_q  <= 1'b0;
      stp_s2_q  <= 1'b0;
      stp_s3_q  <= 1'b0;
      wps_s1_q  <= 1'b1;
      wps_s2_q  <= 1'b1;
      stg_s1_q  <= 1'b0;
      stg_s2_q  <= 1'b0;
      stg_s3_q  <= 1'b0;
      wp_seen_q <= 1'b0;
      busy_q    <= 1'b0;
      cnt_q     <= '0;
      stored_q  <= '{default: STORED_RESET};
    end else begin
      stp_s1_q  <= I_FRAME_STOP;
      stp_s2_q  <= stp_s1_q;
      stp_s3_q  <= stp_s2_q;
      wps_s1_q  <= I_WP_N;
      wps_s2_q  <= wps_s1_q;
      stg_s1_q  <= stgl_q;
      stg_s2_q  <= stg_s1_q;
      stg_s3_q  <= stg_s2_q;
      wp_seen_q <= wp_seen_d;
      busy_q    <= busy_d;
      cnt_q     <= cnt_d;
      stored_q  <= stored_d;
    end
  end

endmodule
`default_nettype wire

// *** hdl/qpc_pkg.sv ***
/*
  Package for the quad potentiometer command unit: instruction field layout,
  opcodes, link states, reset values and the programming-cycle timing.
  Assumes a 20 MHz system clock; the serial clock is supplied by the bus master.
*/
package qpc_pkg;

  // geometry
  localparam int unsigned NUM_POTS     = 4;
  localparam int unsigned NUM_SETTINGS = 4;
  localparam int unsigned NUM_TAPS     = 256;
  localparam int unsigned NUM_STORED   = NUM_POTS * NUM_SETTINGS;

  // slave address byte layout
  localparam int unsigned ADDR_TYPE_MSB = 7;
  localparam int unsigned ADDR_TYPE_LSB = 4;
  localparam int unsigned ADDR_HW_MSB   = 3;
  localparam int unsigned ADDR_HW_LSB   = 0;
  // value is arbitrary, not the real device-type identifier
  localparam logic [3:0]  DEV_TYPE_DEFAULT = 4'hA;

  // instruction byte layout
  localparam int unsigned OPC_MSB = 7;
  localparam int unsigned OPC_LSB = 4;
  localparam int unsigned SEL_MSB = 3;
  localparam int unsigned SEL_LSB = 2;
  localparam int unsigned POT_MSB = 1;
  localparam int unsigned POT_LSB = 0;

  // opcodes
  localparam logic [3:0] OP_GANG_S2W  = 4'h1;
  localparam logic [3:0] OP_STEP      = 4'h2;
  localparam logic [3:0] OP_GANG_W2S  = 4'h8;
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'hA;
  localparam logic [3:0] OP_RD_STORED = 4'hB;
  localparam logic [3:0] OP_WR_STORED = 4'hC;
  localparam logic [3:0] OP_COPY_S2W  = 4'hD;
  localparam logic [3:0] OP_COPY_W2S  = 4'hE;

  // bit slots within one byte frame
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;

  // wiper limits and reset contents
  localparam logic [7:0] WIPER_MAX    = 8'hFF;
  localparam logic [7:0] WIPER_MIN    = 8'h00;
  localparam logic [7:0] STORED_RESET = 8'h80;

  // programming cycle: longest time, rounded down
  localparam int unsigned CLK_FREQ_HZ  = 20_000_000;
  localparam int unsigned PROG_TIME_MS = 10;
  localparam int unsigned PROG_CYCLES  = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned PROG_CNT_W   = 18;

  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_INSTR, L_DATA, L_READ, L_STEP, L_WAIT
  } qpc_link_e;

  typedef enum logic [1:0] {
    PEND_WRITE, PEND_COPY, PEND_GANG
  } qpc_pend_e;

endpackage

// *** tb/qpc_bus_master.sv ***
/*
  Behavioural bus master: makes the serial clock only inside frames.
  Assumes i_sda is the resolved wire level with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module qpc_bus_master (
  // link lines
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_start,
  output logic      o_stop,
  input wire logic  i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_start = 1'b0;
    o_stop = 1'b0;
  end
  // 48 ns serial period, data changes only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    o_sda = b;
    #12 o_scl = 1'b1;
    #12 s = i_sda;
    #12 o_scl = 1'b0;
    o_start = 1'b0;
    #12;
  endtask
  task automatic frame_begin();
    o_sda = 1'b0;
    o_start = 1'b1;
    #24 o_scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(output logic [7:0] b, input logic mack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!mack, s);
  endtask
  task automatic steps(input int n, input logic up);
    logic s;
    for (int i = 0; i < n; i++) bit_io(up, s);
  endtask
  task automatic frame_end();
    o_sda = 1'b0;
    #12 o_scl = 1'b1;
    #12 o_sda = 1'b1;
    o_stop = 1'b1;
    #400 o_stop = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/qpc_cu_checker.sv ***
/*
  Port checker for the command unit: programming cycle, data wire, taps.
  Assumes it is bound to qpc_command_unit and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module qpc_cu_checker
  import qpc_pkg::*;
#(parameter int unsigned PROG_CYC_PARM = PROG_CYCLES) (
  // clocks and reset
  input wire logic                     I_CLOCK,
  input wire logic                     I_NRST,
  input wire logic                     I_SCL,
  // link and pins
  input wire logic                     I_FRAME_START,
  input wire logic                     I_FRAME_STOP,
  input wire logic                     I_WP_N,
  input wire logic                     O_SDA,
  input wire logic                     O_SDA_OE_N,
  // pot side
  input wire logic [NUM_POTS*NUM_TAPS-1:0] O_TAP_SEL,
  input wire logic [NUM_POTS*8-1:0]    O_WIPER,
  input wire logic                     O_BUSY
);
  logic [17:0] cnt_q;
  logic [17:0] cnt_d;
  // counts busy cycles so the cycle length can be bounded
  always_comb cnt_d = O_BUSY ? cnt_q + 18'h1 : 18'h0;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) cnt_q <= 18'h0;
    else cnt_q <= cnt_d;
  end
  sequence s_prog_start;
    $rose(O_BUSY);
  endsequence
  AST_PROG_AFTER_STOP: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    s_prog_start |-> $past(I_FRAME_STOP, 2)) else $error("programming began without stop");
  AST_PROG_WP_BLOCK: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    s_prog_start |-> $past(I_WP_N, 2)) else $error("programming began while protected");
  AST_BUSY_RELEASED: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    O_BUSY |-> O_SDA_OE_N) else $error("data driven while busy");
  AST_BUSY_LIMIT: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    cnt_q <= PROG_CYC_PARM) else $error("programming too long");
  AST_BUSY_FULL: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    O_BUSY && (cnt_q < PROG_CYC_PARM - 4) |=> O_BUSY) else $error("programming cut short");
  AST_OPEN_DRAIN: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    !O_SDA_OE_N |-> !O_SDA) else $error("data wire driven high");
  AST_RESET_LOAD: assert property (@(posedge I_CLOCK)
    $rose(I_NRST) |-> O_WIPER == {NUM_POTS{STORED_RESET}}) else $error("wiper not loaded");
  AST_TAP0: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    $onehot(O_TAP_SEL[255:0]) && O_TAP_SEL[O_WIPER[7:0]]) else $error("pot 0 tap wrong");
  AST_TAP3: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    O_TAP_SEL[{2'h3, O_WIPER[31:24]}]) else $error("pot 3 tap wrong");
  AST_START_IDLE: assert property (@(posedge I_SCL) disable iff (!I_NRST)
    I_FRAME_START |-> O_SDA_OE_N) else $error("data driven at frame start");
endmodule
bind qpc_command_unit qpc_cu_checker #(.PROG_CYC_PARM(PROG_CYC_PARM)) qpc_cu_checker_i (
  .I_CLOCK, .I_NRST, .I_SCL, .I_FRAME_START, .I_FRAME_STOP, .I_WP_N,
  .O_SDA, .O_SDA_OE_N, .O_TAP_SEL, .O_WIPER, .O_BUSY);
`default_nettype wire

// *** tb/quad_pot_i2c_command_unit_test.sv ***
/*
  Self-checking bench for the command unit with a bus master model.
  Assumes a shortened programming cycle; the serial clock is the model's.
*/
`timescale 1ns/100ps
`default_nettype none
module quad_pot_i2c_command_unit_test;
  import qpc_pkg::*;
  localparam int unsigned PCYC = 400;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic [3:0] hwa = 4'h5;
  logic scl, m_sda, fst, fsp, o_sda, oe_n, busy, sda_w;
  logic [1023:0] taps;
  logic [31:0] wip;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] adr;
  always #25 clk = ~clk;
  assign sda_w = m_sda & (oe_n | o_sda);
  assign adr = {DEV_TYPE_DEFAULT, hwa};
  qpc_command_unit #(.PROG_CYC_PARM(PCYC)) qpc_command_unit_i (
    .I_CLOCK(clk), .I_NRST(nrst), .I_SCL(scl), .I_SDA(sda_w), .I_FRAME_START(fst),
    .I_FRAME_STOP(fsp), .O_SDA(o_sda), .O_SDA_OE_N(oe_n), .I_WP_N(wp_n),
    .I_HW_ADDR(hwa), .O_TAP_SEL(taps), .O_WIPER(wip), .O_BUSY(busy));
  qpc_bus_master qpc_bus_master_i (.o_scl(scl), .o_sda(m_sda), .o_start(fst),
    .o_stop(fsp), .i_sda(sda_w));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] a, input logic [7:0] ins, input logic [7:0] d,
                     input int nb, output logic [2:0] k);
    k = 3'h0;
    qpc_bus_master_i.frame_begin();
    qpc_bus_master_i.put_byte(a, k[2]);
    if (nb > 1) qpc_bus_master_i.put_byte(ins, k[1]);
    if (nb > 2) qpc_bus_master_i.put_byte(d, k[0]);
    qpc_bus_master_i.frame_end();
  endtask
  task automatic rd(input logic [7:0] ins, output logic [7:0] v);
    logic k;
    qpc_bus_master_i.frame_begin();
    qpc_bus_master_i.put_byte(adr, k);
    qpc_bus_master_i.put_byte(ins, k);
    qpc_bus_master_i.get_byte(v, 1'b0);
    qpc_bus_master_i.frame_end();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 2 * PCYC && busy === 1'b1; i++) @(posedge clk);
  endtask
  task automatic t_wiper();
    logic [2:0] k;
    logic [7:0] v;
    cmd(adr, {OP_WR_WIPER, 4'h2}, 8'h3C, 3, k);
    chk("wr acks", 3'h7, k);
    rd({OP_RD_WIPER, 4'h2}, v);
    chk("rd wiper", 8'h3C, v);
    chk("wiper 2", 8'h3C, wip[23:16]);
    cmd({DEV_TYPE_DEFAULT, ~hwa}, {OP_WR_WIPER, 4'h2}, 8'h11, 3, k);
    chk("hw addr", 3'h0, k);
    cmd({~DEV_TYPE_DEFAULT, hwa}, {OP_WR_WIPER, 4'h2}, 8'h11, 3, k);
    chk("type id", 3'h0, k);
    chk("wiper kept", 8'h3C, wip[23:16]);
  endtask
  task automatic t_stored();
    logic [2:0] k;
    logic [7:0] v;
    cmd(adr, {OP_WR_STORED, 4'hD}, 8'h5A, 3, k);
    chk("busy", 1'b1, busy);
    cmd(adr, 8'h00, 8'h00, 1, k);
    chk("poll busy", 3'h0, k);
    wait_idle();
    cmd(adr, 8'h00, 8'h00, 1, k);
    chk("poll done", 3'h4, k);
    rd({OP_RD_STORED, 4'hD}, v);
    chk("rd stored", 8'h5A, v);
    cmd(adr, {OP_COPY_S2W, 4'hD}, 8'h00, 2, k);
    chk("copy", 8'h5A, wip[15:8]);
    cmd(adr, {OP_GANG_S2W, 4'hC}, 8'h00, 2, k);
    chk("gang", {STORED_RESET, STORED_RESET, 8'h5A, STORED_RESET}, wip);
    cmd(adr, {OP_COPY_W2S, 4'h5}, 8'h00, 2, k);
    chk("w2s busy", 1'b1, busy);
    wait_idle();
    rd({OP_RD_STORED, 4'h5}, v);
    chk("w2s", 8'h5A, v);
  endtask
  task automatic t_protect();
    logic [2:0] k;
    logic [7:0] v;
    @(negedge clk) wp_n = 1'b0;
    cmd(adr, {OP_WR_STORED, 4'h8}, 8'h77, 3, k);
    chk("wp acks", 3'h6, k);
    chk("wp busy", 1'b0, busy);
    rd({OP_RD_STORED, 4'h8}, v);
    chk("wp kept", STORED_RESET, v);
    @(negedge clk) wp_n = 1'b1;
  endtask
  task automatic t_step();
    logic [2:0] k;
    cmd(adr, {OP_WR_WIPER, 4'h0}, 8'hFE, 3, k);
    qpc_bus_master_i.frame_begin();
    qpc_bus_master_i.put_byte(adr, k[2]);
    qpc_bus_master_i.put_byte({OP_STEP, 4'h0}, k[1]);
    qpc_bus_master_i.steps(3, 1'b1);
    qpc_bus_master_i.frame_end();
    chk("step acks", 3'h7, k);
    chk("step top", WIPER_MAX, wip[7:0]);
    qpc_bus_master_i.frame_begin();
    qpc_bus_master_i.put_byte(adr, k[2]);
    qpc_bus_master_i.put_byte({OP_STEP, 4'h0}, k[1]);
    qpc_bus_master_i.steps(2, 1'b0);
    qpc_bus_master_i.frame_end();
    chk("step down", 8'hFD, wip[7:0]);
    chk("tap", 1'b1, taps[8'hFD]);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (4) @(posedge clk);
    chk("reset wipers", {NUM_POTS{STORED_RESET}}, wip);
    t_wiper();
    t_stored();
    t_protect();
    t_step();
    give_verdict();
  end
endmodule
`default_nettype wire
